// *** inc/alu_params.svh ***
// offsets, field positions and reset values of the accumulator alu block
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define ACC_OFF 32'h0000_0000
`define STATUS_OFF 32'h0000_0004
`define CMD_OFF 32'h0000_0008
`define MEM_BASE 32'h0000_0100

`define ACC_RST 8'h00
`define STATUS_RST 5'h00
`define STATUS_W 5

`define FLG_C 0
`define FLG_AC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_SC 4

`define CMD_OP_LSB 0
`define CMD_ADDR_LSB 8
`define CMD_IMM_LSB 16
`define CMD_BUSY_BIT 31

`endif

// *** inc/alu_pkg.sv ***
// types shared by the accumulator alu block
package alu_pkg;
    typedef enum logic [1:0] {
        op_add_acc_into_memory,
        op_and_memory,
        op_and_immediate,
        op_reserved
    } op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_fetch,
        st_exec
    } state_t;
endpackage : alu_pkg

// *** inc/mem_if.sv ***
// single port byte memory connection between control and storage
`timescale 1ns/1ns
`default_nettype none
interface mem_if #(parameter int AW = 6) ();
    logic en;
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport ram (input en, input we, input addr, input wdata, output rdata);
endinterface : mem_if
`default_nettype wire

// *** logic/data_ram.sv ***
// data memory with registered read port
`timescale 1ns/1ns
`default_nettype none
module data_ram #(
    parameter int AW = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    mem_if.ram m
);
    logic [7:0] mem_q [0:(1<<AW)-1];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (m.en && !m.we) begin
            rdata_d = mem_q[m.addr];
        end
    end

    always_ff @(posedge hclk) begin
        if (m.en && m.we) begin
            mem_q[m.addr] <= m.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign m.rdata = rdata_q;
endmodule : data_ram
`default_nettype wire

// *** logic/acc_alu_top.sv ***
// accumulator add and and-instruction datapath behind an ahb-lite slave
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "alu_params.svh"
module acc_alu_top #(
    parameter int MEM_AW = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic busy
);
    import alu_pkg::*;

    mem_if #(.AW(MEM_AW)) mem ();

    data_ram #(.AW(MEM_AW)) u_ram (
        .hclk(hclk),
        .hresetn(hresetn),
        .m(mem.ram)
    );

    // byte window of the data memory
    function automatic logic is_mem(input logic [31:0] a);
        logic [31:0] off;
        off = a - `MEM_BASE;
        return off < (32'(1) << (MEM_AW + 2));
    endfunction : is_mem

    function automatic logic [MEM_AW-1:0] mem_index(input logic [31:0] a);
        logic [31:0] off;
        off = a - `MEM_BASE;
        return off[MEM_AW+1:2];
    endfunction : mem_index

    state_t state_q, state_d;
    op_t op_q, op_d;
    logic [MEM_AW-1:0] opaddr_q, opaddr_d;
    logic [7:0] imm_q, imm_d;
    logic [7:0] accumulator_reg_q, accumulator_reg_d;
    logic [`STATUS_W-1:0] status_q, status_d;
    logic dph_valid_q, dph_valid_d;
    logic dph_write_q, dph_write_d;
    logic [31:0] dph_addr_q, dph_addr_d;
    logic rd_wait_q, rd_wait_d;

    logic [8:0] sum9;
    logic [4:0] half5;
    logic overflow_flag;
    logic auxiliary_carry_flag;
    logic signed_carry_flag;
    logic [7:0] and_mem_res;
    logic [7:0] and_imm_res;
    logic rd_mem;
    logic dph_done;

    // sum and flags of accumulator plus memory operand
    assign sum9 = {1'b0, accumulator_reg_q} + {1'b0, mem.rdata};
    assign half5 = {1'b0, accumulator_reg_q[3:0]} + {1'b0, mem.rdata[3:0]};
    assign auxiliary_carry_flag = half5[4];
    assign overflow_flag = (accumulator_reg_q[7] == mem.rdata[7]) &&
                           (sum9[7] != accumulator_reg_q[7]);
    assign signed_carry_flag = overflow_flag ^ sum9[7];
    assign and_mem_res = accumulator_reg_q & mem.rdata;
    assign and_imm_res = accumulator_reg_q & imm_q;

    // bus data phase handling
    assign rd_mem = !dph_write_q && is_mem(dph_addr_q);
    assign hreadyout = !dph_valid_q || (state_q == st_idle && (!rd_mem || rd_wait_q));
    assign dph_done = dph_valid_q && hreadyout;
    assign hresp = 1'b0;
    assign busy = (state_q != st_idle);

    always_comb begin
        hrdata = 32'h0000_0000;
        if (is_mem(dph_addr_q)) begin
            hrdata = {24'h00_0000, mem.rdata};
        end else if (dph_addr_q == `ACC_OFF) begin
            hrdata = {24'h00_0000, accumulator_reg_q};
        end else if (dph_addr_q == `STATUS_OFF) begin
            hrdata = {{(32-`STATUS_W){1'b0}}, status_q};
        end else if (dph_addr_q == `CMD_OFF) begin
            hrdata[`CMD_BUSY_BIT] = busy;
            hrdata[`CMD_IMM_LSB +: 8] = imm_q;
            hrdata[`CMD_ADDR_LSB +: MEM_AW] = opaddr_q;
            hrdata[`CMD_OP_LSB +: 2] = op_q;
        end
    end

    // memory port: sequencer first, bus when idle
    always_comb begin
        mem.en = 1'b0;
        mem.we = 1'b0;
        mem.addr = mem_index(dph_addr_q);
        mem.wdata = hwdata[7:0];
        if (state_q == st_fetch) begin
            mem.en = 1'b1;
            mem.addr = opaddr_q;
        end else if (state_q == st_exec && op_q == op_add_acc_into_memory) begin
            mem.en = 1'b1;
            mem.we = 1'b1;
            mem.addr = opaddr_q;
            mem.wdata = sum9[7:0];
        end else if (state_q == st_idle && dph_valid_q && is_mem(dph_addr_q)) begin
            mem.en = dph_write_q || !rd_wait_q;
            mem.we = dph_write_q;
        end
    end

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        opaddr_d = opaddr_q;
        imm_d = imm_q;
        accumulator_reg_d = accumulator_reg_q;
        status_d = status_q;
        dph_valid_d = dph_valid_q;
        dph_write_d = dph_write_q;
        dph_addr_d = dph_addr_q;
        rd_wait_d = rd_wait_q;
        if (dph_valid_q && rd_mem && state_q == st_idle && !rd_wait_q) begin
            rd_wait_d = 1'b1;
        end
        if (dph_done) begin
            rd_wait_d = 1'b0;
            dph_valid_d = 1'b0;
        end
        if (hready) begin
            dph_valid_d = hsel && htrans[1];
            dph_write_d = hwrite;
            dph_addr_d = haddr;
        end
        // register writes land only while idle
        if (dph_done && dph_write_q) begin
            if (dph_addr_q == `ACC_OFF) begin
                accumulator_reg_d = hwdata[7:0];
            end else if (dph_addr_q == `STATUS_OFF) begin
                status_d = hwdata[`STATUS_W-1:0];
            end else if (dph_addr_q == `CMD_OFF) begin
                op_d = op_t'(hwdata[`CMD_OP_LSB +: 2]);
                opaddr_d = hwdata[`CMD_ADDR_LSB +: MEM_AW];
                imm_d = hwdata[`CMD_IMM_LSB +: 8];
                unique case (op_t'(hwdata[`CMD_OP_LSB +: 2]))
                    op_add_acc_into_memory: state_d = st_fetch;
                    op_and_memory: state_d = st_fetch;
                    op_and_immediate: state_d = st_exec;
                    op_reserved: state_d = st_idle;
                endcase
            end
        end
        unique case (state_q)
            st_idle: begin
            end
            st_fetch: begin
                state_d = st_exec;
            end
            st_exec: begin
                state_d = st_idle;
                unique case (op_q)
                    op_add_acc_into_memory: begin
                        status_d[`FLG_C] = sum9[8];
                        status_d[`FLG_AC] = auxiliary_carry_flag;
                        status_d[`FLG_Z] = (sum9[7:0] == 8'h00);
                        status_d[`FLG_OV] = overflow_flag;
                        status_d[`FLG_SC] = signed_carry_flag;
                    end
                    op_and_memory: begin
                        accumulator_reg_d = and_mem_res;
                        status_d[`FLG_Z] = (and_mem_res == 8'h00);
                    end
                    op_and_immediate: begin
                        accumulator_reg_d = and_imm_res;
                        status_d[`FLG_Z] = (and_imm_res == 8'h00);
                    end
                    op_reserved: begin
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_idle;
            op_q <= op_add_acc_into_memory;
            opaddr_q <= '0;
            imm_q <= 8'h00;
            accumulator_reg_q <= `ACC_RST;
            status_q <= `STATUS_RST;
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_addr_q <= 32'h0000_0000;
            rd_wait_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            opaddr_q <= opaddr_d;
            imm_q <= imm_d;
            accumulator_reg_q <= accumulator_reg_d;
            status_q <= status_d;
            dph_valid_q <= dph_valid_d;
            dph_write_q <= dph_write_d;
            dph_addr_q <= dph_addr_d;
            rd_wait_q <= rd_wait_d;
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic exec_add;
    logic exec_and;
    assign exec_add = (state_q == st_exec) && (op_q == op_add_acc_into_memory);
    assign exec_and = (state_q == st_exec) &&
                      (op_q == op_and_memory || op_q == op_and_immediate);

    a_add_sum_write: assert property (exec_add |-> mem.we && mem.en &&
        mem.addr == opaddr_q && mem.wdata == 8'(accumulator_reg_q + mem.rdata))
        else $error("add result not written to operand location");

    a_add_acc_flags: assert property (exec_add |=>
        accumulator_reg_q == $past(accumulator_reg_q) &&
        status_q[`FLG_C] == $past(sum9[8]) &&
        status_q[`FLG_Z] == ($past(sum9[7:0]) == 8'h00) && state_q == st_idle)
        else $error("add changed accumulator or flags wrong");

    a_and_mem_res: assert property ((state_q == st_fetch && op_q == op_and_memory)
        ##1 exec_and |=> accumulator_reg_q == ($past(accumulator_reg_q) & $past(mem.rdata)))
        else $error("memory and result wrong");

    a_and_imm_res: assert property ((state_q == st_exec && op_q == op_and_immediate) |=>
        accumulator_reg_q == ($past(accumulator_reg_q) & $past(imm_q)))
        else $error("immediate and result wrong");

    a_and_zero_only: assert property (exec_and |-> !mem.we ##1
        (status_q & ~(`STATUS_W'(1) << `FLG_Z)) == ($past(status_q) & ~(`STATUS_W'(1) << `FLG_Z))
        && status_q[`FLG_Z] == (accumulator_reg_q == 8'h00))
        else $error("and touched flags other than zero");

    c_add_carry: cover property (exec_add && sum9[8]);
    c_and_mem_zero: cover property (exec_and && op_q == op_and_memory && and_mem_res == 8'h00);
    c_and_imm: cover property (exec_and && op_q == op_and_immediate);
    c_stall: cover property (busy && dph_valid_q && !hreadyout);
endmodule : acc_alu_top
`default_nettype wire

// *** verification/bus_master_model.sv ***
// ahb-lite master standing in for the host that writes commands to the sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= w ? wd : ~wd;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask : xfer
endmodule : bus_master_model
`default_nettype wire

// *** verification/test_acc_add_and_ops.sv ***
// self-checking bench of the accumulator add and and datapath
`timescale 1ns/1ns
`default_nettype none
`include "alu_params.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_acc_add_and_ops;
    import alu_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, busy;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    always #4 hclk = ~hclk;

    acc_alu_top acc_alu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .busy(busy));
    bus_master_model bus_master_model_i (.hclk(hclk), .hreadyout(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus_master_model_i.xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        bus_master_model_i.xfer(1'b0, a, 32'h0000_0000, d);
        `CHK(hresp, 1'b0)
    endtask : rd

    task automatic run(input op_t op, input logic [7:0] a, input logic [7:0] imm);
        wr(`CMD_OFF, {8'h00, imm, a, 6'h00, op});
    endtask : run

    // expected status after an add: ov, z, ac, c and signed carry
    function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] f;
        s = a + b;
        f = 5'h00;
        f[`FLG_C] = s[8];
        f[`FLG_AC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        f[`FLG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        f[`FLG_SC] = f[`FLG_OV] ^ s[7];
        f[`FLG_Z] = s[7:0] == 8'h00;
        return f;
    endfunction : add_flags

    task automatic test_reset;
        rd(`ACC_OFF, r);
        `CHK(r, 32'h0000_0000)
        rd(`STATUS_OFF, r);
        `CHK(r, 32'h0000_0000)
        wr(32'h0000_0040, 32'h0000_00ff);
        rd(32'h0000_0040, r);
        `CHK(r, 32'h0000_0000)
        $display("test_reset done");
    endtask : test_reset

    task automatic test_add;
        logic [7:0] av [3] = '{8'h8f, 8'h80, 8'h05};
        logic [7:0] bv [3] = '{8'h91, 8'h80, 8'h0a};
        for (int i = 0; i < 3; i++) begin
            wr(`ACC_OFF, {24'h0, av[i]});
            wr(`STATUS_OFF, 32'h0000_0000);
            wr(`MEM_BASE + 32'(4 * (i + 3)), {24'h0, bv[i]});
            run(op_add_acc_into_memory, 8'(i + 3), 8'h00);
            rd(`MEM_BASE + 32'(4 * (i + 3)), r);
            `CHK(r, {24'h0, 8'(av[i] + bv[i])})
            rd(`ACC_OFF, r);
            `CHK(r, {24'h0, av[i]})
            rd(`STATUS_OFF, r);
            `CHK(r, {27'h0, add_flags(av[i], bv[i])})
        end
        $display("test_add done");
    endtask : test_add

    // one and case; memory operand at byte 9 or immediate
    task automatic and_case(input op_t op, input logic [7:0] a, input logic [7:0] b,
            input logic [4:0] s);
        logic [7:0] res;
        res = a & b;
        wr(`ACC_OFF, {24'h0, a});
        wr(`STATUS_OFF, {27'h0, s});
        wr(`MEM_BASE + 32'h0000_0024, {24'h0, op == op_and_memory ? b : ~b});
        run(op, 8'h09, b);
        @(negedge hclk);
        `CHK(busy, 1'b1)
        @(posedge hclk);
        rd(`ACC_OFF, r);
        `CHK(r, {24'h0, res})
        rd(`STATUS_OFF, r);
        `CHK(r, {27'h0, (s & 5'h1b) | {2'b00, res == 8'h00, 2'b00}})
        rd(`CMD_OFF, r);
        `CHK(r, {8'h00, b, 8'h09, 6'h00, op})
    endtask : and_case

    task automatic test_and_memory;
        and_case(op_and_memory, 8'hf0, 8'h0f, 5'h1b);
        and_case(op_and_memory, 8'h3c, 8'hf6, 5'h1f);
        rd(`MEM_BASE + 32'h0000_0024, r);
        `CHK(r, 32'h0000_00f6)
        $display("test_and_memory done");
    endtask : test_and_memory

    task automatic test_and_immediate;
        and_case(op_and_immediate, 8'haa, 8'h55, 5'h00);
        and_case(op_and_immediate, 8'hc3, 8'h81, 5'h1f);
        // reserved op code must leave accumulator and flags alone
        run(op_reserved, 8'h09, 8'h00);
        @(negedge hclk);
        `CHK(busy, 1'b0)
        @(posedge hclk);
        rd(`ACC_OFF, r);
        `CHK(r, 32'h0000_0081)
        rd(`STATUS_OFF, r);
        `CHK(r, 32'h0000_001b)
        $display("test_and_immediate done");
    endtask : test_and_immediate

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_add();
        test_and_memory();
        test_and_immediate();
        print_verdict();
    end
endmodule : test_acc_add_and_ops
`default_nettype wire
